// *** src/scc_chopper.sv ***
module scc_chopper #(
   parameter logic [11:0] PERIOD = 12'(scc_pkg::SCC_PERIOD_DEF)
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic ext_osc_select,
   input  wire logic chopper_osc_pin,
   input  wire logic coil_a_polarity,
   input  wire logic coil_b_polarity,
   input  wire logic coil_a_mixdecay_n,
   input  wire logic coil_b_mixdecay_n,
   input  wire logic coil_a_at_target,
   input  wire logic coil_b_at_target,
   output logic      bridge_a_high_first,
   output logic      bridge_a_high_second,
   output logic      bridge_a_low_first,
   output logic      bridge_a_low_second,
   output logic      bridge_b_high_first,
   output logic      bridge_b_high_second,
   output logic      bridge_b_low_first,
   output logic      bridge_b_low_second,
   output logic      osc_out
);
   scc_bridge_if bra ();
   scc_bridge_if brb ();
   logic [11:0] div;
   logic        osc;
   logic        osc_q;
   logic        ext_rise;
   logic        ext_fall;
   logic [11:0] ext_period;
   logic [11:0] ext_cnt;
   logic        osc_sel;
   logic [11:0] since_rise;

   // Internal oscillator: square wave with period PERIOD cycles
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 12'h000;
         osc <= 1'b0;
      end else if (div + 12'h001 >= (PERIOD >> 1)) begin
         div <= 12'h000;
         osc <= !osc;
      end else begin
         div <= div + 12'h001;
      end
   end

   // External square wave edge detection and period measurement
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q      <= 1'b0;
         ext_cnt    <= 12'h000;
         ext_period <= PERIOD;
      end else begin
         osc_q <= chopper_osc_pin;
         if (ext_rise) begin
            ext_cnt    <= 12'h000;
            // Saturate so a very slow clock never reads as period 0
            ext_period <= (ext_cnt == 12'hfff) ? ext_cnt : ext_cnt + 12'h001;
         end else if (ext_cnt != 12'hfff) begin
            ext_cnt <= ext_cnt + 12'h001;
         end
      end
   end
   assign ext_rise = chopper_osc_pin && !osc_q;
   assign ext_fall = !chopper_osc_pin && osc_q;
   // Chopper clock in use, shown on osc_out
   assign osc_sel  = ext_osc_select ? chopper_osc_pin : osc;

   // Bridge A on rising edge, B on falling edge
   logic int_rise;
   logic int_fall;
   assign int_rise = osc == 1'b0 && div + 12'h001 >= (PERIOD >> 1);
   assign int_fall = osc == 1'b1 && div + 12'h001 >= (PERIOD >> 1);
   assign bra.start      = ext_osc_select ? ext_rise : int_rise;
   assign brb.start      = ext_osc_select ? ext_fall : int_fall;
   assign bra.period     = ext_osc_select ? ext_period : PERIOD;
   assign brb.period     = ext_osc_select ? ext_period : PERIOD;
   assign bra.polarity   = coil_a_polarity;
   assign brb.polarity   = coil_b_polarity;
   assign bra.mixdecay_n = coil_a_mixdecay_n;
   assign brb.mixdecay_n = coil_b_mixdecay_n;
   assign bra.at_target  = coil_a_at_target;
   assign brb.at_target  = coil_b_at_target;

   scc_bridge u_a (.mclk(mclk), .rst_n(rst_n), .br(bra));
   scc_bridge u_b (.mclk(mclk), .rst_n(rst_n), .br(brb));

   // Registered switch outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_a_high_first  <= 1'b0;
         bridge_a_high_second <= 1'b0;
         bridge_a_low_first   <= 1'b0;
         bridge_a_low_second  <= 1'b0;
         bridge_b_high_first  <= 1'b0;
         bridge_b_high_second <= 1'b0;
         bridge_b_low_first   <= 1'b0;
         bridge_b_low_second  <= 1'b0;
         osc_out              <= 1'b0;
      end else begin
         bridge_a_high_first  <= bra.high_first;
         bridge_a_high_second <= bra.high_second;
         bridge_a_low_first   <= bra.low_first;
         bridge_a_low_second  <= bra.low_second;
         bridge_b_high_first  <= brb.high_first;
         bridge_b_high_second <= brb.high_second;
         bridge_b_low_first   <= brb.low_first;
         bridge_b_low_second  <= brb.low_second;
         osc_out              <= osc_sel;
      end
   end

   sequence a_start_s;
      bra.start;
   endsequence
   half_offset_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ext_osc_select && bra.start |-> !brb.start) else $error("starts coincide");
   start_edge_a: assert property (@(posedge mclk) disable iff (!rst_n)
      a_start_s and !ext_osc_select |=> osc) else $error("A not on rising edge");
   no_shoot_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(bridge_a_high_first && bridge_a_low_first)) else $error("shoot through");
   b_no_shoot_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(bridge_b_high_first && bridge_b_low_first)
      && !(bridge_b_high_second && bridge_b_low_second))
      else $error("B shoot through");

   // Cycles since the internal rise; B must start half a period later
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         since_rise <= 12'hfff;
      end else if (int_rise) begin
         since_rise <= 12'h000;
      end else if (since_rise != 12'hfff) begin
         since_rise <= since_rise + 12'h001;
      end
   end
   half_gap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      int_fall && since_rise != 12'hfff
      |-> since_rise == 12'((PERIOD >> 1) - 12'h001))
      else $error("B start not half a period after A");

   // osc_out repeats the selected chopper clock one cycle late
   osc_follow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      1'b1
      |=> osc_out == $past(osc_sel))
      else $error("osc_out not following chopper clock");

   // Bridge enters on phase, then a high switch shows at the pins
   sequence a_on_s;
      bra.phase == scc_pkg::SCC_ON ##1 (bridge_a_high_first || bridge_a_high_second);
   endsequence
   sequence b_on_s;
      brb.phase == scc_pkg::SCC_ON ##1 (bridge_b_high_first || bridge_b_high_second);
   endsequence

   // External clock: A starts on its rise, B on its fall
   ext_a_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ext_osc_select && ext_rise |=> a_on_s)
      else $error("A not started by external rise");
   ext_b_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ext_osc_select && ext_fall |=> b_on_s)
      else $error("B not started by external fall");

   // Pin patterns one cycle after each phase
   a_on_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bra.phase == scc_pkg::SCC_ON
      |=> bridge_a_high_first != $past(coil_a_polarity)
      && bridge_a_high_second == $past(coil_a_polarity))
      else $error("A on pattern");
   b_on_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      brb.phase == scc_pkg::SCC_ON
      |=> bridge_b_high_first != $past(coil_b_polarity)
      && bridge_b_high_second == $past(coil_b_polarity))
      else $error("B on pattern");
   a_fast_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bra.phase == scc_pkg::SCC_FAST
      |=> !bridge_a_high_first && !bridge_a_high_second
      && bridge_a_low_first == $past(coil_a_polarity)
      && bridge_a_low_second != $past(coil_a_polarity))
      else $error("A fast decay pattern");
   b_fast_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      brb.phase == scc_pkg::SCC_FAST
      |=> !bridge_b_high_first && !bridge_b_high_second
      && bridge_b_low_first == $past(coil_b_polarity)
      && bridge_b_low_second != $past(coil_b_polarity))
      else $error("B fast decay pattern");
   a_slow_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      bra.phase == scc_pkg::SCC_SLOW
      |=> !bridge_a_high_first && !bridge_a_high_second
      && bridge_a_low_first && bridge_a_low_second)
      else $error("A slow decay pattern");
   b_slow_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
      brb.phase == scc_pkg::SCC_SLOW
      |=> !bridge_b_high_first && !bridge_b_high_second
      && bridge_b_low_first && bridge_b_low_second)
      else $error("B slow decay pattern");

   // A polarity change on one bridge leaves the other bridge alone
   b_alone_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $changed(coil_b_polarity) && !$changed(coil_a_polarity) && !bra.start
      && bra.phase == scc_pkg::SCC_SLOW
      |=> bra.phase == scc_pkg::SCC_SLOW)
      else $error("A disturbed by B polarity");
   a_alone_a: assert property (@(posedge mclk) disable iff (!rst_n)
      $changed(coil_a_polarity) && !$changed(coil_b_polarity) && !brb.start
      && brb.phase == scc_pkg::SCC_SLOW
      |=> brb.phase == scc_pkg::SCC_SLOW)
      else $error("B disturbed by A polarity");
endmodule

// *** pkg/scc_pkg.sv ***
package scc_pkg;
   // Chopper phase codes, Gray along on -> fast -> slow
   typedef enum logic [1:0] {
      SCC_ON   = 2'b00,
      SCC_FAST = 2'b01,
      SCC_SLOW = 2'b11
   } scc_phase_type;

   localparam int          SCC_PERIOD_W     = 12;
   // Default chopper period: 40 MHz / 1600 = 25 kHz
   localparam int          SCC_PERIOD_DEF   = 1600;
   // Fast decay share of the period without mixed decay (1/8)
   localparam int          SCC_FAST_SHIFT   = 3;
   localparam logic [1:0]  SCC_SYNC_RESET   = 2'b00;
endpackage

// *** pkg/scc_bridge_if.sv ***
interface scc_bridge_if;
   logic       start;
   logic       polarity;
   logic       mixdecay_n;
   logic       at_target;
   logic [11:0] period;
   logic       high_first;
   logic       high_second;
   logic       low_first;
   logic       low_second;
   logic [1:0] phase;
   modport ctrl (output start, output polarity, output mixdecay_n, output at_target,
                 output period, input high_first, input high_second, input low_first,
                 input low_second, input phase);
   modport bridge (input start, input polarity, input mixdecay_n, input at_target,
                   input period, output high_first, output high_second,
                   output low_first, output low_second, output phase);
endinterface

// *** src/scc_bridge.sv ***
module scc_bridge (
   input  wire logic    mclk,
   input  wire logic    rst_n,
   scc_bridge_if.bridge br
);
   scc_pkg::scc_phase_type phase;
   logic [11:0]            count;
   logic [11:0]            on_len;
   logic                   pol_q;
   logic                   pol_change;
   logic [11:0]            fast_len;
   logic [11:0]            base_fast;

   assign pol_change = br.polarity != pol_q;
   // Base fast decay share of period
   assign base_fast  = br.period >> scc_pkg::SCC_FAST_SHIFT;
   // Mixed decay: fast decay shrinks as on time grows
   always_comb begin
      if (br.mixdecay_n) begin
         fast_len = base_fast;
      end else if (on_len >= base_fast) begin
         fast_len = 12'h001;
      end else begin
         fast_len = base_fast - on_len;
      end
   end

   // Previous polarity for change detection
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) pol_q <= 1'b0;
      else pol_q <= br.polarity;
   end

   // Phase sequencing per chopper period
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         phase  <= scc_pkg::SCC_ON;
         count  <= 12'h000;
         on_len <= 12'h000;
      end else if (pol_change || br.start) begin
         phase <= scc_pkg::SCC_ON;
         count <= 12'h000;
      end else begin
         if (count != 12'hfff) count <= count + 12'h001;
         unique case (phase)
            scc_pkg::SCC_ON: if (br.at_target || count + 12'h001 >= br.period) begin
               phase  <= scc_pkg::SCC_FAST;
               on_len <= count;
            end
            scc_pkg::SCC_FAST: if (count >= on_len + fast_len) begin
               phase <= scc_pkg::SCC_SLOW;
            end
            scc_pkg::SCC_SLOW: ;
         endcase
      end
   end

   // Switch pattern; low polarity drives first output high
   always_comb begin
      br.high_first  = phase == scc_pkg::SCC_ON && !br.polarity;
      br.high_second = phase == scc_pkg::SCC_ON && br.polarity;
      br.low_first   = phase == scc_pkg::SCC_SLOW
                       || (phase != scc_pkg::SCC_SLOW && br.polarity);
      br.low_second  = phase == scc_pkg::SCC_SLOW
                       || (phase != scc_pkg::SCC_SLOW && !br.polarity);
   end
   assign br.phase = phase;

   fast_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
      phase == scc_pkg::SCC_FAST |-> !br.high_first && !br.high_second
      && (br.low_first != br.low_second)) else $error("fast decay pattern");
   slow_lows_a: assert property (@(posedge mclk) disable iff (!rst_n)
      phase == scc_pkg::SCC_SLOW |-> br.low_first && br.low_second)
      else $error("slow decay pattern");
   pol_restart_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pol_change |=> phase == scc_pkg::SCC_ON && count == 12'h000)
      else $error("no restart on polarity");
   target_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
      phase == scc_pkg::SCC_ON && br.at_target && !pol_change && !br.start
      |=> phase == scc_pkg::SCC_FAST) else $error("on not ended");
   phase_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
      phase == scc_pkg::SCC_SLOW && !pol_change && !br.start
      |=> phase != scc_pkg::SCC_FAST) else $error("bad phase order");
endmodule

// *** test/scc_coil_model.sv ***
module scc_coil_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       drive_on,
   input  wire logic [7:0] on_len,
   output logic            at_target
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] on_cnt;

   // Coil current ramps while a high switch conducts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt <= 8'h00;
      end else if (drive_on) begin
         on_cnt <= on_cnt + 8'h01;
      end else begin
         on_cnt <= 8'h00;
      end
   end

   // Comparator trips once the ramp reaches its target
   assign at_target = drive_on && (on_cnt >= on_len);
endmodule

// *** test/stepper_chopper_control_tb.sv ***
module stepper_chopper_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P = 40;
   localparam int F = P >> scc_pkg::SCC_FAST_SHIFT;
   // External square wave: 400 cycles per period is 100 kHz at 40 MHz
   localparam int EP = 400;
   localparam int EH = EP / 2;
   // 9-bit duty word; half scale is 50 percent duty
   localparam logic [8:0] DUTY_HALF = 9'h100;
   logic       ext_osc_select;
   logic       osc_pin = 1'b0;
   int         osc_cnt = 0;
   logic       osc_out;
   logic [7:0] b_limit;
   logic       mclk;
   logic       rst_n;
   logic       coil_a_polarity;
   logic       coil_b_polarity;
   logic       coil_a_mixdecay_n;
   logic       coil_b_mixdecay_n;
   logic       coil_a_at_target;
   logic       coil_b_at_target;
   logic [3:0] a_sw;
   logic [3:0] b_sw;
   int         fail_count;
   int         compares;
   int         n1;
   int         n2;
   int         n3;

   scc_chopper #(.PERIOD(12'(P))) dut (
      .mclk(mclk), .rst_n(rst_n), .ext_osc_select(ext_osc_select), .chopper_osc_pin(osc_pin),
      .coil_a_polarity(coil_a_polarity), .coil_b_polarity(coil_b_polarity),
      .coil_a_mixdecay_n(coil_a_mixdecay_n), .coil_b_mixdecay_n(coil_b_mixdecay_n),
      .coil_a_at_target(coil_a_at_target), .coil_b_at_target(coil_b_at_target),
      .bridge_a_high_first(a_sw[3]), .bridge_a_high_second(a_sw[2]),
      .bridge_a_low_first(a_sw[1]), .bridge_a_low_second(a_sw[0]),
      .bridge_b_high_first(b_sw[3]), .bridge_b_high_second(b_sw[2]),
      .bridge_b_low_first(b_sw[1]), .bridge_b_low_second(b_sw[0]), .osc_out(osc_out));

   // Current comparators of both coils
   scc_coil_model coil_a (.mclk(mclk), .rst_n(rst_n), .drive_on(a_sw[3] | a_sw[2]),
                          .on_len(8'h03), .at_target(coil_a_at_target));
   scc_coil_model coil_b (.mclk(mclk), .rst_n(rst_n), .drive_on(b_sw[3] | b_sw[2]),
                          .on_len(b_limit), .at_target(coil_b_at_target));

   // External chopper square wave, toggled at falling edges
   always @(negedge mclk) begin
      if (!ext_osc_select) begin
         osc_cnt <= 0;
      end else if (osc_cnt == EH - 1) begin
         osc_cnt <= 0;
         osc_pin <= !osc_pin;
      end else begin
         osc_cnt <= osc_cnt + 1;
      end
   end

   // Clock at 40 MHz
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Waits at falling edges for a switch pattern, counting cycles
   task automatic wait_sw(input bit is_b, input logic [3:0] pat, input int bound,
                          output int n);
      n = 0;
      while ((is_b ? b_sw : a_sw) !== pat) begin
         @(negedge mclk);
         n++;
         if (n > bound) begin
            fail_count++;
            $display("[ERR] switches expected %0h seen %0h", pat, is_b ? b_sw : a_sw);
            wrap_up();
         end
      end
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      coil_a_polarity = 1'b0;
      coil_b_polarity = 1'b0;
      coil_a_mixdecay_n = 1'b1;
      coil_b_mixdecay_n = 1'b1;
      ext_osc_select = 1'b0;
      b_limit = 8'h03;
      fail_count = 0;
      compares = 0;
      repeat (3) @(negedge mclk);
      check("switches in reset", 0, {a_sw, b_sw});
      rst_n = 1'b1;
      // One full cycle of coil A, polarity low
      wait_sw(0, 4'b0011, 3 * P, n1);
      wait_sw(0, 4'b1001, P, n1);
      wait_sw(0, 4'b0001, P, n1);
      wait_sw(0, 4'b0011, P, n2);
      wait_sw(0, 4'b1001, P, n3);
      check("period", P, n1 + n2 + n3);
      check("fast length", F, n2);
      check("on phase ended", 1, n1 < P / 4);
      check("osc_out at A start", 1, osc_out);
      // Coil B starts half a period later
      wait_sw(1, 4'b0011, P, n1);
      wait_sw(1, 4'b1001, P, n2);
      check("b offset", P / 2, (n1 + n2) % P);
      check("osc_out at B start", 0, osc_out);
      // Mixed decay shortens fast decay
      coil_a_mixdecay_n = 1'b0;
      wait_sw(0, 4'b0011, P, n1);
      wait_sw(0, 4'b1001, P, n1);
      wait_sw(0, 4'b0001, P, n1);
      wait_sw(0, 4'b0011, P, n2);
      check("mixed fast shorter", 1, n2 > 0 && n2 < F);
      coil_a_mixdecay_n = 1'b1;
      // Polarity flip restarts A, leaves B on its own period
      wait_sw(1, 4'b0011, P, n1);
      wait_sw(1, 4'b1001, P, n1);
      coil_a_polarity = 1'b1;
      wait_sw(0, 4'b0110, 3, n3);
      wait_sw(1, 4'b0011, P, n1);
      wait_sw(1, 4'b1001, P, n2);
      check("b period undisturbed", P, n1 + n2 + n3);
      wait_sw(0, 4'b0010, P, n1);
      wait_sw(0, 4'b0011, P, n1);
      check("pattern after flip", 4'b0011, a_sw);
      // External chopper clock: A on its rise, B on its fall
      ext_osc_select = 1'b1;
      wait_sw(0, 4'b0110, 2 * EP, n1);
      check("osc_out at ext rise", 1, osc_out);
      wait_sw(1, 4'b1001, EP, n2);
      check("ext b offset", EH, n2);
      check("osc_out at ext fall", 0, osc_out);
      wait_sw(0, 4'b0110, EP, n1);
      wait_sw(0, 4'b0010, EP, n1);
      wait_sw(0, 4'b0011, EP, n2);
      wait_sw(0, 4'b0110, EP, n3);
      check("ext fast length", EP >> scc_pkg::SCC_FAST_SHIFT, n2);
      check("ext period", EP, n1 + n2 + n3);
      // Voltage mode: polarity PWM on coil B, mixed decay held off
      coil_a_mixdecay_n = 1'b1;
      coil_b_mixdecay_n = 1'b1;
      b_limit = 8'h04;
      for (int i = 0; i < 4; i++) begin
         coil_b_polarity = !coil_b_polarity;
         wait_sw(1, coil_b_polarity ? 4'b0110 : 4'b1001, 3, n1);
         check("pwm restart delay", 2, n1);
         repeat (int'(DUTY_HALF >> 5)) @(negedge mclk);
      end
      wrap_up();
   end
endmodule
